//--- rtl/vssc_core.sv
// Summary of operation
// R1: sample code only at cycle start
// R2: changed code waits one switching cycle
// R3: accept code only if unchanged throughout
// R4: step 25mV every two switching cycles
// R5: PWM outputs high-impedance in shutdown
// R6: enable ignored until supply reset clears
// R7: shutdown until enable comparator above threshold
// R8: grounded rate-select stops oscillator, shuts down
// R9: releasing rate-select restarts oscillator, soft-start
// R10: code 11111 means shutdown, no load
// R11: all four conditions start soft-start immediately
// R12: 11-bit soft-start counter, phase-clock steps
// R13: ramp rises zero to 140% reference
// R14: ramp current falls 160uA to zero
// R15: soft-start target is lower of both
// R16: power-ok open drain, window comparators
// R17: power-ok low in shutdown, rises above UV; while aresetn is low the core releases it (power_ok_oe low)
// R18: power-ok drops only on disable or fault
// R19: code 00000 1.550, minus 25mV per step
// R20: over-current blanked during code transition
// R21: step toward target, never overshoot
// R22: processor holds code one full cycle
module vssc_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire vssc_pkg::vssc_pins_t pins,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output vssc_pkg::vssc_drive_t drive,
  output logic [11:0] target_mv,
  output logic [7:0] ramp_ua
);

  vssc_pkg::vssc_pins_t pin_s;
  vssc_pkg::vssc_mode_t mode;
  vssc_pkg::vssc_vs_t vs_state;

  logic [15:0] period;
  logic [15:0] cycle_cnt;
  logic cycle_start;
  logic osc_run;

  logic [4:0] accepted_code;
  logic [4:0] pending_code;
  logic [10:0] reference_mv;
  logic [10:0] goal_mv;
  logic step_phase;

  logic [10:0] ss_count;
  logic [11:0] ramp_mv;
  logic [7:0] ramp_now_ua;
  logic [11:0] next_target_mv;

  logic start_ok;
  logic oc_blank;
  logic fault;
  logic power_ok;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  vssc_sync #(
    .W($bits(vssc_pkg::vssc_pins_t))
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pins),
    .q(pin_s)
  );

  vssc_ramp u_ramp (
    .count(ss_count),
    .reference_mv(reference_mv),
    .ramp_mv(ramp_mv),
    .ramp_ua(ramp_now_ua)
  );

  // oscillator: runs while the disable input is released
  assign osc_run = pin_s.rate_select_disable; // R8 R9

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle_cnt <= '0;
      cycle_start <= 1'b0;
    end else if (!osc_run) begin
      cycle_cnt <= '0; // R8
      cycle_start <= 1'b0;
    end else if (cycle_cnt >= period - 16'h0001) begin
      cycle_cnt <= '0;
      cycle_start <= 1'b1;
    end else begin
      cycle_cnt <= cycle_cnt + 16'h0001;
      cycle_start <= 1'b0;
    end
  end

  // code validation at phase-1 cycle boundaries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vs_state <= vssc_pkg::VS_IDLE;
      accepted_code <= vssc_pkg::CODE_NO_LOAD;
      pending_code <= vssc_pkg::CODE_NO_LOAD;
    end else if (cycle_start) begin // R1
      case (vs_state)
        vssc_pkg::VS_IDLE: begin
          if (pin_s.voltage_select_code != accepted_code) begin
            pending_code <= pin_s.voltage_select_code; // R2
            vs_state <= vssc_pkg::VS_VALIDATE;
          end
        end
        vssc_pkg::VS_VALIDATE: begin
          if (pin_s.voltage_select_code == pending_code) begin
            accepted_code <= pending_code; // R3
            vs_state <= vssc_pkg::VS_IDLE;
          end else if (pin_s.voltage_select_code == accepted_code) begin
            vs_state <= vssc_pkg::VS_IDLE;
          end else begin
            pending_code <= pin_s.voltage_select_code; // R2
          end
        end
        default: vs_state <= vssc_pkg::VS_IDLE;
      endcase
    end
  end

  assign goal_mv = vssc_pkg::code_to_mv(accepted_code); // R19

  // reference stepping toward the accepted code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_mv <= '0;
      step_phase <= 1'b0;
    end else if (mode == vssc_pkg::SHUTDOWN) begin
      if (accepted_code != vssc_pkg::CODE_NO_LOAD) begin
        reference_mv <= goal_mv;
      end
      step_phase <= 1'b0;
    end else if (accepted_code == vssc_pkg::CODE_NO_LOAD || reference_mv == goal_mv) begin
      step_phase <= 1'b0; // R21
    end else if (cycle_start) begin
      step_phase <= ~step_phase;
      if (step_phase) begin
        if (reference_mv < goal_mv) begin
          reference_mv <= reference_mv + vssc_pkg::STEP_MV; // R4 R21
        end else begin
          reference_mv <= reference_mv - vssc_pkg::STEP_MV; // R4 R21
        end
      end
    end
  end

  // over-current blanked while a transition is running
  assign oc_blank = (mode != vssc_pkg::SHUTDOWN) && (reference_mv != goal_mv); // R20

  // supply and enable comparators carry their own hysteresis
  assign start_ok = pin_s.por_ok // R6
                    && pin_s.enable_ok // R7
                    && osc_run // R8
                    && (accepted_code != vssc_pkg::CODE_NO_LOAD); // R10

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= vssc_pkg::SHUTDOWN;
      ss_count <= '0;
    end else if (!start_ok) begin
      mode <= vssc_pkg::SHUTDOWN; // R10
      ss_count <= '0;
    end else begin
      case (mode)
        vssc_pkg::SHUTDOWN: begin
          mode <= vssc_pkg::SOFT_START; // R11
          ss_count <= '0;
        end
        vssc_pkg::SOFT_START: begin
          if (cycle_start) begin
            if (ss_count == vssc_pkg::SS_LAST) begin
              mode <= vssc_pkg::REGULATE; // R12
            end else begin
              ss_count <= ss_count + 11'h001; // R12
            end
          end
        end
        vssc_pkg::REGULATE: begin
          ss_count <= vssc_pkg::SS_LAST;
        end
        default: mode <= vssc_pkg::SHUTDOWN;
      endcase
    end
  end

  // regulation target seen by the error amplifier
  always_comb begin
    case (mode)
      vssc_pkg::SOFT_START: begin
        if (ramp_mv < {1'b0, reference_mv}) begin
          next_target_mv = ramp_mv; // R13 R15
        end else begin
          next_target_mv = {1'b0, reference_mv}; // R15
        end
      end
      vssc_pkg::REGULATE: next_target_mv = {1'b0, reference_mv};
      default: next_target_mv = '0;
    endcase
  end

  assign fault = pin_s.ov_trip || (pin_s.oc_trip && !oc_blank) || !pin_s.uv_ok; // R16 R20

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_ok <= 1'b0;
    end else if (mode == vssc_pkg::SHUTDOWN) begin
      power_ok <= 1'b0; // R17
    end else if (!power_ok && !fault) begin
      power_ok <= 1'b1; // R17
    end else if (power_ok && fault) begin
      power_ok <= 1'b0; // R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
      target_mv <= '0;
      ramp_ua <= '0;
    end else begin
      drive.pwm_o <= '0;
      drive.pwm_oe <= {2{mode != vssc_pkg::SHUTDOWN}}; // R5
      drive.power_ok_o <= 1'b0;
      drive.power_ok_oe <= !power_ok; // R16
      drive.osc_run <= osc_run;
      drive.oc_blank <= oc_blank;
      target_mv <= next_target_mv;
      if (mode == vssc_pkg::SOFT_START) begin
        ramp_ua <= ramp_now_ua; // R14
      end else begin
        ramp_ua <= '0;
      end
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= vssc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == vssc_pkg::OFFS_PERIOD) begin
          s_axi_bresp <= vssc_pkg::RESP_OKAY;
        end else if (aw_addr == vssc_pkg::OFFS_STATUS || aw_addr == vssc_pkg::OFFS_REFERENCE
                     || aw_addr == vssc_pkg::OFFS_SOFTSTART) begin
          s_axi_bresp <= vssc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= vssc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // switching period register, byte lanes 0 and 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period <= vssc_pkg::SW_PERIOD_CYCLES;
    end else if (aw_held && w_held && !s_axi_bvalid && aw_addr == vssc_pkg::OFFS_PERIOD) begin
      if (w_strb[0] && w_strb[1]) begin
        period <= (w_data[15:0] < vssc_pkg::PERIOD_MIN) ? vssc_pkg::PERIOD_MIN : w_data[15:0];
      end else if (w_strb[0]) begin
        period <= ({period[15:8], w_data[7:0]} < vssc_pkg::PERIOD_MIN)
                  ? vssc_pkg::PERIOD_MIN : {period[15:8], w_data[7:0]};
      end else if (w_strb[1]) begin
        period <= ({w_data[15:8], period[7:0]} < vssc_pkg::PERIOD_MIN)
                  ? vssc_pkg::PERIOD_MIN : {w_data[15:8], period[7:0]};
      end
    end
  end

  // AXI4-Lite read
  vssc_pkg::vssc_status_t status_word;
  vssc_pkg::vssc_reference_t reference_word;
  vssc_pkg::vssc_softstart_t softstart_word;

  always_comb begin
    status_word = '0;
    status_word.osc_run = osc_run;
    status_word.validating = (vs_state == vssc_pkg::VS_VALIDATE);
    status_word.accepted_code = accepted_code;
    status_word.oc_blank = oc_blank;
    status_word.power_ok = power_ok;
    status_word.mode = mode;
    reference_word = '0;
    reference_word.target_mv = next_target_mv;
    reference_word.reference_mv = reference_mv;
    softstart_word = '0;
    softstart_word.ramp_ua = ramp_now_ua;
    softstart_word.count = ss_count;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= vssc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= vssc_pkg::RESP_OKAY;
      if (s_axi_araddr == vssc_pkg::OFFS_PERIOD) begin
        s_axi_rdata <= {16'h0000, period};
      end else if (s_axi_araddr == vssc_pkg::OFFS_STATUS) begin
        s_axi_rdata <= status_word;
      end else if (s_axi_araddr == vssc_pkg::OFFS_REFERENCE) begin
        s_axi_rdata <= reference_word;
      end else if (s_axi_araddr == vssc_pkg::OFFS_SOFTSTART) begin
        s_axi_rdata <= softstart_word;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= vssc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- include/vssc_pkg.sv
package vssc_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SW_PERIOD_NS = 2000;
  localparam logic [15:0] SW_PERIOD_CYCLES = 16'(SW_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [15:0] PERIOD_MIN = 16'h0002;

  // voltage-select code and reference scale
  localparam logic [4:0] CODE_NO_LOAD = 5'h1F;
  localparam logic [5:0] CODE_TOP_UNITS = 6'h3E;
  localparam logic [10:0] STEP_MV = 11'h019;

  // soft-start
  localparam int SS_BITS = 11;
  localparam logic [10:0] SS_LAST = 11'h7FF;
  localparam int SS_SPAN = 2048;
  localparam int RAMP_NUM = 7;
  localparam int RAMP_DEN = 10240;
  localparam int RAMP_CURRENT_UA = 160;

  // register map, byte addresses
  localparam logic [7:0] OFFS_PERIOD = 8'h00;
  localparam logic [7:0] OFFS_STATUS = 8'h04;
  localparam logic [7:0] OFFS_REFERENCE = 8'h08;
  localparam logic [7:0] OFFS_SOFTSTART = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SHUTDOWN, SOFT_START, REGULATE} vssc_mode_t;
  typedef enum logic {VS_IDLE, VS_VALIDATE} vssc_vs_t;

  typedef struct packed {
    logic por_ok;
    logic enable_ok;
    logic rate_select_disable;
    logic uv_ok;
    logic ov_trip;
    logic oc_trip;
    logic [4:0] voltage_select_code;
  } vssc_pins_t;

  typedef struct packed {
    logic [1:0] pwm_o;
    logic [1:0] pwm_oe;
    logic power_ok_o;
    logic power_ok_oe;
    logic osc_run;
    logic oc_blank;
  } vssc_drive_t;

  typedef struct packed {
    logic [20:0] zero;
    logic osc_run;
    logic validating;
    logic [4:0] accepted_code;
    logic oc_blank;
    logic power_ok;
    logic [1:0] mode;
  } vssc_status_t;

  typedef struct packed {
    logic [3:0] zero_hi;
    logic [11:0] target_mv;
    logic [4:0] zero_lo;
    logic [10:0] reference_mv;
  } vssc_reference_t;

  typedef struct packed {
    logic [7:0] zero_hi;
    logic [7:0] ramp_ua;
    logic [4:0] zero_lo;
    logic [10:0] count;
  } vssc_softstart_t;

  function automatic logic [10:0] code_to_mv(input logic [4:0] code);
    logic [5:0] units;
    units = CODE_TOP_UNITS - {1'b0, code};
    return 11'(units * STEP_MV);
  endfunction

endpackage

//--- rtl/vssc_sync.sv
module vssc_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

//--- rtl/vssc_ramp.sv
module vssc_ramp (
  input wire logic [10:0] count,
  input wire logic [10:0] reference_mv,
  output logic [11:0] ramp_mv,
  output logic [7:0] ramp_ua
);

  int ramp_full;
  int current_full;

  always_comb begin
    // 0 .. 140% of reference across the counter span
    ramp_full = (int'(reference_mv) * vssc_pkg::RAMP_NUM * int'(count)) / vssc_pkg::RAMP_DEN;
    // 160 uA falling to zero
    current_full = (vssc_pkg::RAMP_CURRENT_UA * (vssc_pkg::SS_SPAN - int'(count) - 1))
                   / (vssc_pkg::SS_SPAN - 1);
    ramp_mv = 12'(ramp_full);
    ramp_ua = 8'(current_full);
  end

endmodule

//--- tb/vssc_chk.sv
module vssc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire vssc_pkg::vssc_pins_t pins,
  input wire vssc_pkg::vssc_drive_t drive,
  input wire logic [11:0] target_mv,
  input wire logic [7:0] ramp_ua
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence run_s;
    drive.pwm_oe == 2'h3 && $past(drive.pwm_oe) == 2'h3;
  endsequence
  sequence rsd_low_s;
    !pins.rate_select_disable [*6];
  endsequence
  pwm_hiz_a: assert property (
    drive.pwm_oe != 2'h3 |-> drive.pwm_oe == 2'h0 && drive.pwm_o == 2'h0
      && target_mv == 12'h000 && ramp_ua == 8'h00)
    else $error("outputs active in shutdown");
  rsd_stop_a: assert property (
    rsd_low_s |-> drive.pwm_oe == 2'h0 && !drive.osc_run)
    else $error("grounded rate select did not stop");
  rsd_restart_a: assert property (
    $rose(pins.rate_select_disable) |-> ##[1:6] drive.osc_run)
    else $error("oscillator did not restart");
  por_gate_a: assert property (
    !pins.por_ok [*6] |-> drive.pwm_oe == 2'h0)
    else $error("running without supply");
  enable_gate_a: assert property (
    !pins.enable_ok [*6] |-> drive.pwm_oe == 2'h0)
    else $error("running without enable");
  pok_drain_a: assert property (drive.power_ok_o == 1'b0)
    else $error("power ok driven high");
  ov_window_a: assert property (
    pins.ov_trip [*5] |-> drive.power_ok_oe)
    else $error("power ok high in over-voltage");
  pok_shut_a: assert property (
    (drive.pwm_oe == 2'h0) [*3] |-> drive.power_ok_oe)
    else $error("power ok released in shutdown");
  ramp_fall_a: assert property (
    run_s |-> ramp_ua <= $past(ramp_ua) && ramp_ua <= 8'hA0)
    else $error("ramp current rose");
  ref_step_a: assert property (
    run_s ##0 (ramp_ua == 8'h00 && $past(ramp_ua) == 8'h00 && $changed(target_mv))
      |-> target_mv == $past(target_mv) + 12'h019 || target_mv + 12'h019 == $past(target_mv))
    else $error("reference step not 25 mV");
endmodule

bind vssc_core vssc_chk vssc_chk_i (
  .aclk(aclk),
  .aresetn(aresetn),
  .pins(pins),
  .drive(drive),
  .target_mv(target_mv),
  .ramp_ua(ramp_ua)
);

//--- tb/vssc_partner.sv
module vssc_partner (
  input wire logic aclk,
  input wire vssc_pkg::vssc_drive_t drive,
  input wire logic [11:0] target_mv,
  input wire logic inject_ov,
  input wire logic inject_oc,
  output logic uv_ok,
  output logic ov_trip,
  output logic oc_trip,
  output logic power_ok_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] vout = 12'h000;
  // output slews toward target, decays with both switches off
  always @(posedge aclk) begin
    if (drive.pwm_oe != 2'h3) begin
      vout <= (vout > 12'h008) ? vout - 12'h008 : 12'h000;
    end else if (vout + 12'h008 < target_mv) begin
      vout <= vout + 12'h008;
    end else begin
      vout <= target_mv;
    end
  end
  assign uv_ok = 13'(vout) + 13'h015E >= 13'(target_mv);
  assign ov_trip = inject_ov;
  assign oc_trip = inject_oc;
  // pull-up on the open-drain line
  assign power_ok_pin = drive.power_ok_oe ? drive.power_ok_o : 1'b1;
endmodule

//--- tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PER = 32'h0000_0004;
  logic aclk, aresetn, por_ok, en_ok, rsd, inj_ov, inj_oc, uv_ok, ov_trip, oc_trip, pok;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ramp_ua;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] s_axi_wstrb;
  logic [11:0] target_mv;
  logic [4:0] code;
  vssc_pkg::vssc_pins_t pins;
  vssc_pkg::vssc_drive_t drive;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int n, t0, i, k;
  assign pins = {por_ok, en_ok, rsd, uv_ok, ov_trip, oc_trip, code};
  vssc_core vssc_core_i (.aclk, .aresetn, .pins, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .drive, .target_mv, .ramp_ua);
  vssc_partner vssc_partner_i (.aclk, .drive, .target_mv, .inject_ov(inj_ov),
    .inject_oc(inj_oc), .uv_ok, .ov_trip, .oc_trip, .power_ok_pin(pok));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_rsp(input logic [1:0] g, input logic [1:0] e);
    cmp({30'h0, g}, {30'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] obs(input int s);
    case (s)
      0: return 32'(drive.pwm_oe);
      1: return 32'(pok);
      default: return 32'(drive.osc_run);
    endcase
  endfunction
  task automatic wait_for(input int s, input logic [31:0] w, input int lim);
    int m;
    m = 0;
    @(negedge aclk);
    while (obs(s) !== w && m < lim) begin
      @(negedge aclk);
      m++;
    end
    cmp(obs(s), w);
  endtask
  task automatic step_wait(output int m);
    logic [11:0] p;
    p = target_mv;
    m = 0;
    do begin
      @(negedge aclk);
      m++;
    end while (target_mv === p && m < 200);
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    end_sim();
  end
  initial begin
    aresetn = 1'b0;
    por_ok = 1'b1;
    en_ok = 1'b1;
    rsd = 1'b1;
    code = 5'h1F;
    inj_ov = 1'b0;
    inj_oc = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(8'h00, rd, rsp);
    cmp(rd, 32'h0000_00C8);
    rd_reg(8'h04, rd, rsp);
    cmp(rd & 32'h0000_03FF, 32'h0000_01F0);
    rd_reg(8'h10, rd, rsp);
    cmp(rd, 32'h0);
    cmp_rsp(rsp, 2'h2);
    wr(8'h10, 32'h1, rsp);
    cmp_rsp(rsp, 2'h2);
    wr(8'h04, 32'hFFFF_FFFF, rsp);
    cmp_rsp(rsp, 2'h0);
    // byte lanes of the period word one at a time
    s_axi_wstrb <= 4'h2;
    wr(8'h00, 32'h0000_0100, rsp);
    cmp_rsp(rsp, 2'h0);
    s_axi_wstrb <= 4'h1;
    wr(8'h00, 32'h0000_0001, rsp);
    s_axi_wstrb <= 4'hF;
    rd_reg(8'h00, rd, rsp);
    cmp(rd, 32'h0000_0101);
    // period below the floor is clamped
    wr(8'h00, 32'h0, rsp);
    rd_reg(8'h00, rd, rsp);
    cmp(rd, 32'h0000_0002);
    wr(8'h00, PER, rsp);
    cmp_rsp(rsp, 2'h0);
    rd_reg(8'h00, rd, rsp);
    cmp(rd, PER);
    $display("test registers done");
    code <= 5'h0A;
    wait_for(0, 32'h3, 80);
    t0 = cyc;
    cmp(32'(ramp_ua), 32'hA0);
    repeat (1000 * PER) @(negedge aclk);
    rd_reg(8'h0C, rd, rsp);
    k = rd[10:0];
    cmp(rd[23:16], 32'hA0 * (32'h7FF - k) / 32'h7FF);
    rd_reg(8'h08, rd, rsp);
    cmp(rd[10:0], 32'h514);
    cmp(rd[27:16] >= 32'h514 * 7 * k / 32'h2800 && rd[27:16] <= 32'h514 * 7 * (k + 2) / 32'h2800,
      1);
    cmp(32'(pok), 1);
    wait (cyc == t0 + 2040 * PER);
    rd_reg(8'h04, rd, rsp);
    cmp(rd[1:0], 32'h1);
    wait (cyc == t0 + 2056 * PER);
    rd_reg(8'h04, rd, rsp);
    cmp(rd[1:0], 32'h2);
    cmp(32'(target_mv), 32'h514);
    $display("test soft_start done");
    for (i = 0; i < 2; i++) begin
      @(posedge aclk);
      code <= i ? 5'h0B : 5'h08;
      step_wait(n);
      cmp(n >= 3 * PER && n <= 5 * PER + 2, 1);
      cmp(32'(drive.oc_blank), 1);
      @(posedge aclk);
      inj_oc <= i[0];
      for (k = 1; k < 2 + i; k++) begin
        step_wait(n);
        cmp(n, 2 * PER);
        if (i && k == 1) cmp(32'(pok), 1);
      end
      repeat (40) @(negedge aclk);
      cmp(32'(target_mv), i ? 32'h4FB : 32'h546);
      cmp(32'(drive.oc_blank), 0);
    end
    // code held for just one period: gone again at the validating boundary
    @(posedge aclk);
    code <= 5'h02;
    repeat (PER) @(posedge aclk);
    code <= 5'h0B;
    repeat (40) @(negedge aclk);
    cmp(32'(target_mv), 32'h4FB);
    wait_for(1, 0, 20);
    @(posedge aclk);
    inj_oc <= 1'b0;
    wait_for(1, 1, 20);
    @(posedge aclk);
    inj_ov <= 1'b1;
    wait_for(1, 0, 20);
    repeat (4) @(posedge aclk);
    inj_ov <= 1'b0;
    wait_for(1, 1, 20);
    $display("test voltage_step done");
    for (i = 0; i < 4; i++) begin
      @(posedge aclk);
      case (i)
        0: por_ok <= 1'b0;
        1: en_ok <= 1'b0;
        2: rsd <= 1'b0;
        default: code <= 5'h1F;
      endcase
      wait_for(0, 0, 60);
      wait_for(1, 0, 10);
      if (i == 2) wait_for(2, 0, 10);
      repeat (4) @(posedge aclk);
      por_ok <= 1'b1;
      en_ok <= 1'b1;
      rsd <= 1'b1;
      code <= 5'h0B;
      wait_for(0, 32'h3, 60);
      cmp(32'(ramp_ua), 32'hA0);
    end
    $display("test shutdown done");
    end_sim();
  end
endmodule
